// File: rtl/dsp_xfer_pkg.sv
package dsp_xfer_pkg;

  // Opcode prefixes in bits 15:10
  localparam logic [5:0] SINGLE_PREFIX = 6'h3D;
  localparam logic [5:0] XY_PREFIX = 6'h3C;

  // Single transfer field positions
  localparam int PTR_LSB = 8;
  localparam int REG_LSB = 4;
  localparam int STORE_BIT = 0;
  localparam int LONG_BIT = 1;
  localparam int MODE_LSB = 2;

  // Parallel transfer field positions
  localparam int XPTR_BIT = 9;
  localparam int YPTR_BIT = 8;
  localparam int XSEL_BIT = 7;
  localparam int YSEL_BIT = 6;
  localparam int XDIR_BIT = 5;
  localparam int YDIR_BIT = 4;
  localparam int XMODE_LSB = 2;
  localparam int YMODE_LSB = 0;

  // Addressing modes
  localparam logic [1:0] MODE_PREDEC = 2'h0;
  localparam logic [1:0] MODE_PLAIN = 2'h1;
  localparam logic [1:0] MODE_POSTINC = 2'h2;
  localparam logic [1:0] MODE_INDEX = 2'h3;
  localparam logic [1:0] XY_NOACCESS = 2'h0;

  // Pointer steps
  localparam logic [31:0] STEP_WORD = 32'h00000002;
  localparam logic [31:0] STEP_LONG = 32'h00000004;

  // Single transfer register codes
  localparam logic [3:0] REG_A1 = 4'h5;
  localparam logic [3:0] REG_A0 = 4'h7;
  localparam logic [3:0] REG_X0 = 4'h8;
  localparam logic [3:0] REG_X1 = 4'h9;
  localparam logic [3:0] REG_Y0 = 4'hA;
  localparam logic [3:0] REG_Y1 = 4'hB;
  localparam logic [3:0] REG_M0 = 4'hC;
  localparam logic [3:0] REG_A1G = 4'hD;
  localparam logic [3:0] REG_M1 = 4'hE;
  localparam logic [3:0] REG_A0G = 4'hF;

  // General register numbers used as pointers
  localparam logic [2:0] GR2 = 3'h2;
  localparam logic [2:0] GR3 = 3'h3;
  localparam logic [2:0] GR4 = 3'h4;
  localparam logic [2:0] GR5 = 3'h5;
  localparam logic [2:0] GR6 = 3'h6;
  localparam logic [2:0] GR7 = 3'h7;

  localparam int GUARD_W = 8;
  localparam logic [31:0] WORD32_RST = 32'h00000000;
  localparam logic [7:0] GUARD_RST = 8'h00;

  // One memory port request
  typedef struct packed {
    logic sel;
    logic write;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic isLong;
  } mem_req_t;

  // Pointer writeback
  typedef struct packed {
    logic we;
    logic [2:0] num;
    logic [31:0] value;
  } ptr_wb_t;

  // DSP register file contents
  typedef struct packed {
    logic [7:0] a0g;
    logic [7:0] a1g;
    logic [31:0] a0;
    logic [31:0] a1;
    logic [31:0] x0;
    logic [31:0] x1;
    logic [31:0] y0;
    logic [31:0] y1;
    logic [31:0] m0;
    logic [31:0] m1;
  } dsp_regs_t;

endpackage

// File: rtl/ptr_update.sv
`timescale 1ns/1ns
// Address and next-pointer computation for one addressing mode
module ptr_update
  import dsp_xfer_pkg::*;
(
  input wire logic [31:0] ptrVal,
  input wire logic [31:0] indexVal,
  input wire logic [1:0] mode,
  input wire logic isLong,
  output logic [31:0] accAddr,
  output logic [31:0] ptrNext,
  output logic ptrWrite
);

  logic [31:0] step;

  // Step and mode selection
  always_comb
  begin
    step = isLong ? STEP_LONG : STEP_WORD;
    accAddr = ptrVal;
    ptrNext = ptrVal;
    ptrWrite = 1'b0;
    case (mode)
      MODE_PREDEC:
      begin
        accAddr = ptrVal - step;
        ptrNext = ptrVal - step;
        ptrWrite = 1'b1;
      end
      MODE_PLAIN: ptrWrite = 1'b0;
      MODE_POSTINC:
      begin
        ptrNext = ptrVal + step;
        ptrWrite = 1'b1;
      end
      MODE_INDEX:
      begin
        ptrNext = ptrVal + indexVal;
        ptrWrite = 1'b1;
      end
      default: ptrWrite = 1'b0;
    endcase
  end

endmodule

// File: rtl/dsp_data_transfer_decode.sv
`timescale 1ns/1ns
module dsp_data_transfer_decode
  import dsp_xfer_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic instValid,
  input wire logic [15:0] instWord,
  input wire logic [31:0] gr2,
  input wire logic [31:0] gr3,
  input wire logic [31:0] gr4,
  input wire logic [31:0] gr5,
  input wire logic [31:0] gr6,
  input wire logic [31:0] gr7,
  input wire logic [31:0] xIndex,
  input wire logic [31:0] yIndex,
  input wire logic [31:0] mainRdata,
  input wire logic mainGrant,
  input wire logic [15:0] xmemRdata,
  input wire logic [15:0] ymemRdata,
  input wire logic condFlagIn,
  output logic instStall,
  output logic mainSel,
  output logic mainWrite,
  output logic mainLong,
  output logic [31:0] mainAddrBus,
  output logic [31:0] mainWdata,
  output logic xmemSel,
  output logic xmemWrite,
  output logic [31:0] xmemAddr,
  output logic [15:0] xmemWdata,
  output logic ymemSel,
  output logic ymemWrite,
  output logic [31:0] ymemAddr,
  output logic [15:0] ymemWdata,
  output ptr_wb_t ptrWbX,
  output ptr_wb_t ptrWbY,
  output dsp_regs_t dspRegs,
  output logic condFlag
);

  // Return the pointer register number for a single transfer code
  function automatic logic [2:0] singlePtr(input logic [1:0] code);
    case (code)
      2'h0: singlePtr = GR4;
      2'h1: singlePtr = GR5;
      2'h2: singlePtr = GR2;
      default: singlePtr = GR3;
    endcase
  endfunction

  // Read a general register by number
  function automatic logic [31:0] grRead(input logic [2:0] num, input logic [31:0] r2,
    input logic [31:0] r3, input logic [31:0] r4, input logic [31:0] r5,
    input logic [31:0] r6, input logic [31:0] r7);
    case (num)
      GR2: grRead = r2;
      GR3: grRead = r3;
      GR4: grRead = r4;
      GR5: grRead = r5;
      GR6: grRead = r6;
      default: grRead = r7;
    endcase
  endfunction

  logic isSingle, isXy, sStore, sLong, xAct, yAct, xStore, yStore;
  logic [1:0] sMode, xMode, yMode;
  logic [3:0] sReg;
  logic [2:0] sPtrNum, xPtrNum, yPtrNum;
  logic [31:0] sPtrVal, xPtrVal, yPtrVal;
  logic [31:0] sAddr, sPtrNext, xAddr, xPtrNext, yAddr, yPtrNext;
  logic sPtrWe, xPtrWe, yPtrWe, sGo;

  // Field decoding
  always_comb
  begin
    isSingle = instValid && instWord[15:10] == SINGLE_PREFIX;
    isXy = instValid && instWord[15:10] == XY_PREFIX;
    sStore = instWord[STORE_BIT];
    sLong = instWord[LONG_BIT];
    sMode = instWord[MODE_LSB +: 2];
    sReg = instWord[REG_LSB +: 4];
    sPtrNum = singlePtr(instWord[PTR_LSB +: 2]);
    xMode = instWord[XMODE_LSB +: 2];
    yMode = instWord[YMODE_LSB +: 2];
    xAct = isXy && xMode != XY_NOACCESS;
    yAct = isXy && yMode != XY_NOACCESS;
    xStore = instWord[XDIR_BIT];
    yStore = instWord[YDIR_BIT];
    xPtrNum = instWord[XPTR_BIT] ? GR5 : GR4;
    yPtrNum = instWord[YPTR_BIT] ? GR7 : GR6;
    sGo = isSingle && mainGrant;
    sPtrVal = grRead(sPtrNum, gr2, gr3, gr4, gr5, gr6, gr7);
    xPtrVal = grRead(xPtrNum, gr2, gr3, gr4, gr5, gr6, gr7);
    yPtrVal = grRead(yPtrNum, gr2, gr3, gr4, gr5, gr6, gr7);
  end

  // One address unit per transfer path
  ptr_update uSingle (.ptrVal(sPtrVal), .indexVal(xIndex), .mode(sMode), .isLong(sLong),
    .accAddr(sAddr), .ptrNext(sPtrNext), .ptrWrite(sPtrWe));
  ptr_update uX (.ptrVal(xPtrVal), .indexVal(xIndex), .mode(xMode), .isLong(1'b0),
    .accAddr(xAddr), .ptrNext(xPtrNext), .ptrWrite(xPtrWe));
  ptr_update uY (.ptrVal(yPtrVal), .indexVal(yIndex), .mode(yMode), .isLong(1'b0),
    .accAddr(yAddr), .ptrNext(yPtrNext), .ptrWrite(yPtrWe));

  mem_req_t mainReq_r, mainReq_nxt;
  logic xSel_r, xSel_nxt, xWr_r, xWr_nxt, ySel_r, ySel_nxt, yWr_r, yWr_nxt;
  logic [31:0] xAddr_r, xAddr_nxt, yAddr_r, yAddr_nxt;
  logic [15:0] xWd_r, xWd_nxt, yWd_r, yWd_nxt;
  ptr_wb_t wbX_r, wbX_nxt, wbY_r, wbY_nxt;
  logic stall_r, stall_nxt;
  logic [31:0] storeSrc;
  logic sLd_r, sLd_nxt, sLong_r, sLong_nxt, xLd_r, xLd_nxt, yLd_r, yLd_nxt;
  logic xDst_r, xDst_nxt, yDst_r, yDst_nxt, cond_r, cond_nxt;
  logic [3:0] sReg_r, sReg_nxt;
  dsp_regs_t regs_r, regs_nxt;

  // Memory requests and pointer writebacks, issued one cycle after decode
  always_comb
  begin
    case (sReg)
      REG_A1: storeSrc = dspRegs.a1;
      REG_A0: storeSrc = dspRegs.a0;
      REG_X0: storeSrc = dspRegs.x0;
      REG_X1: storeSrc = dspRegs.x1;
      REG_Y0: storeSrc = dspRegs.y0;
      REG_Y1: storeSrc = dspRegs.y1;
      REG_M0: storeSrc = dspRegs.m0;
      REG_M1: storeSrc = dspRegs.m1;
      REG_A1G: storeSrc = {24'h000000, dspRegs.a1g};
      REG_A0G: storeSrc = {24'h000000, dspRegs.a0g};
      default: storeSrc = WORD32_RST;
    endcase
    mainReq_nxt.sel = sGo;
    mainReq_nxt.write = sGo && sStore;
    mainReq_nxt.addr = sAddr;
    mainReq_nxt.isLong = sLong;
    if (sLong || sReg == REG_A1G || sReg == REG_A0G)
      mainReq_nxt.wdata = storeSrc;
    else
      mainReq_nxt.wdata = {16'h0000, storeSrc[31:16]};
    stall_nxt = isSingle && !mainGrant;
    xSel_nxt = xAct;
    xWr_nxt = xAct && xStore;
    xAddr_nxt = xAddr;
    xWd_nxt = instWord[XSEL_BIT] ? dspRegs.a1[31:16] : dspRegs.a0[31:16];
    ySel_nxt = yAct;
    yWr_nxt = yAct && yStore;
    yAddr_nxt = yAddr;
    yWd_nxt = instWord[YSEL_BIT] ? dspRegs.a1[31:16] : dspRegs.a0[31:16];
    wbX_nxt.we = (xAct && xPtrWe) || (sGo && sPtrWe);
    wbX_nxt.num = sGo ? sPtrNum : xPtrNum;
    wbX_nxt.value = sGo ? sPtrNext : xPtrNext;
    wbY_nxt.we = yAct && yPtrWe;
    wbY_nxt.num = yPtrNum;
    wbY_nxt.value = yPtrNext;
    sLd_nxt = sGo && !sStore;
    sLong_nxt = sLong;
    sReg_nxt = sReg;
    xLd_nxt = xAct && !xStore;
    yLd_nxt = yAct && !yStore;
    xDst_nxt = instWord[XSEL_BIT];
    yDst_nxt = instWord[YSEL_BIT];
    cond_nxt = condFlagIn;
  end

  // Request, pending-load and register file flops
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      mainReq_r <= '0;
      xSel_r <= 1'b0;
      xWr_r <= 1'b0;
      xAddr_r <= WORD32_RST;
      xWd_r <= 16'h0000;
      ySel_r <= 1'b0;
      yWr_r <= 1'b0;
      yAddr_r <= WORD32_RST;
      yWd_r <= 16'h0000;
      wbX_r <= '0;
      wbY_r <= '0;
      stall_r <= 1'b0;
      sLd_r <= 1'b0;
      sLong_r <= 1'b0;
      sReg_r <= 4'h0;
      xLd_r <= 1'b0;
      yLd_r <= 1'b0;
      xDst_r <= 1'b0;
      yDst_r <= 1'b0;
      cond_r <= 1'b0;
      regs_r <= '0;
    end
    else
    begin
      mainReq_r <= mainReq_nxt;
      xSel_r <= xSel_nxt;
      xWr_r <= xWr_nxt;
      xAddr_r <= xAddr_nxt;
      xWd_r <= xWd_nxt;
      ySel_r <= ySel_nxt;
      yWr_r <= yWr_nxt;
      yAddr_r <= yAddr_nxt;
      yWd_r <= yWd_nxt;
      wbX_r <= wbX_nxt;
      wbY_r <= wbY_nxt;
      stall_r <= stall_nxt;
      sLd_r <= sLd_nxt;
      sLong_r <= sLong_nxt;
      sReg_r <= sReg_nxt;
      xLd_r <= xLd_nxt;
      yLd_r <= yLd_nxt;
      xDst_r <= xDst_nxt;
      yDst_r <= yDst_nxt;
      cond_r <= cond_nxt;
      regs_r <= regs_nxt;
    end
  end

  // DSP register file update from returned data
  logic [31:0] sVal;

  always_comb
  begin
    regs_nxt = regs_r;
    sVal = sLong_r ? mainRdata : {mainRdata[15:0], 16'h0000};
    if (sLd_r)
    begin
      case (sReg_r)
        REG_A1:
        begin
          regs_nxt.a1 = sVal;
          regs_nxt.a1g = {GUARD_W{sVal[31]}};
        end
        REG_A0:
        begin
          regs_nxt.a0 = sVal;
          regs_nxt.a0g = {GUARD_W{sVal[31]}};
        end
        REG_X0: regs_nxt.x0 = sVal;
        REG_X1: regs_nxt.x1 = sVal;
        REG_Y0: regs_nxt.y0 = sVal;
        REG_Y1: regs_nxt.y1 = sVal;
        REG_M0: regs_nxt.m0 = sVal;
        REG_M1: regs_nxt.m1 = sVal;
        REG_A1G: regs_nxt.a1g = mainRdata[7:0];
        REG_A0G: regs_nxt.a0g = mainRdata[7:0];
        default: regs_nxt = regs_r;
      endcase
    end
    // X and Y loads land in the same cycle
    if (xLd_r)
    begin
      if (xDst_r)
        regs_nxt.x1 = {xmemRdata, 16'h0000};
      else
        regs_nxt.x0 = {xmemRdata, 16'h0000};
    end
    if (yLd_r)
    begin
      if (yDst_r)
        regs_nxt.y1 = {ymemRdata, 16'h0000};
      else
        regs_nxt.y0 = {ymemRdata, 16'h0000};
    end
  end

  // Outputs straight from flip-flops
  assign {mainSel, mainWrite, mainLong} = {mainReq_r.sel, mainReq_r.write, mainReq_r.isLong};
  assign {mainAddrBus, mainWdata} = {mainReq_r.addr, mainReq_r.wdata};
  assign {xmemSel, xmemWrite, xmemAddr, xmemWdata} = {xSel_r, xWr_r, xAddr_r, xWd_r};
  assign {ymemSel, ymemWrite, ymemAddr, ymemWdata} = {ySel_r, yWr_r, yAddr_r, yWd_r};
  assign {ptrWbX, ptrWbY, dspRegs} = {wbX_r, wbY_r, regs_r};
  assign {instStall, condFlag} = {stall_r, cond_r};

endmodule

// File: verif/dsp_data_transfer_decode_monitor.sv
`timescale 1ns/1ns
module dsp_xfer_monitor
  import dsp_xfer_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic instValid,
  input wire logic [15:0] instWord,
  input wire logic [31:0] gr4,
  input wire logic [31:0] gr5,
  input wire logic mainGrant,
  input wire logic [15:0] xmemRdata,
  input wire logic condFlagIn,
  input wire logic instStall,
  input wire logic mainSel,
  input wire logic xmemSel,
  input wire logic xmemWrite,
  input wire logic ymemSel,
  input wire logic ymemWrite,
  input wire ptr_wb_t ptrWbX,
  input wire ptr_wb_t ptrWbY,
  input wire dsp_regs_t dspRegs,
  input wire logic condFlag
);
  // Request classes at the taking edge
  wire isSingle = instValid && instWord[15:10] == SINGLE_PREFIX;
  wire isXy = instValid && instWord[15:10] == XY_PREFIX;
  wire [31:0] xPtr = instWord[XPTR_BIT] ? gr5 : gr4;
  wire xOn = instWord[3:2] != XY_NOACCESS;
  wire yOn = instWord[1:0] != XY_NOACCESS;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // Arbitration and bus choice
  stall_no_grant_a: assert property (isSingle && !mainGrant |=> instStall && !mainSel)
    else $error("single transfer without grant was not stalled");
  main_bus_a: assert property (isSingle && mainGrant |=> mainSel && !instStall && !xmemSel)
    else $error("granted single transfer missed the main bus");
  xy_own_bus_a: assert property (isXy |=> !mainSel && !instStall)
    else $error("parallel transfer touched the main bus");
  // Idle sides, selects and condition flag pass-through
  x_idle_side_a: assert property (isXy && !xOn |=> !xmemSel && !ptrWbX.we)
    else $error("X side active without access");
  y_idle_side_a: assert property (isXy && !yOn |=> !ymemSel && !ptrWbY.we)
    else $error("Y side active without access");
  x_select_a: assert property (isXy && xOn |=> xmemSel && xmemWrite == $past(instWord[XDIR_BIT]))
    else $error("X select or direction wrong");
  y_select_a: assert property (isXy && yOn |=> ymemSel && ymemWrite == $past(instWord[YDIR_BIT]))
    else $error("Y select or direction wrong");
  cond_passed_a: assert property (!$past(rst) |-> condFlag == $past(condFlagIn))
    else $error("condition flag altered");
  // Pointer step and load placement
  x_post_step_a: assert property (isXy && instWord[3:2] == MODE_POSTINC |=>
    ptrWbX.we && ptrWbX.value == $past(xPtr) + STEP_WORD)
    else $error("X post-increment wrong");
  x_load_place_a: assert property (isXy && xOn && !instWord[XDIR_BIT] && instWord[XSEL_BIT]
    |=> ##1 dspRegs.x1 == {$past(xmemRdata), 16'h0000})
    else $error("X load placement wrong");

  cover property (isXy && xOn && yOn);
  cover property (isSingle && !mainGrant);
  cover property (isSingle && mainGrant && instWord[LONG_BIT]);
endmodule

// File: verif/dsp_mem_model.sv
`timescale 1ns/1ns
// Memory partner on the main, X and Y data buses
module dsp_mem_model
(
  input wire logic mclk,
  input wire logic mainSel,
  input wire logic mainWrite,
  input wire logic [31:0] mainAddrBus,
  input wire logic xmemSel,
  input wire logic xmemWrite,
  input wire logic [31:0] xmemAddr,
  input wire logic ymemSel,
  input wire logic ymemWrite,
  input wire logic [31:0] ymemAddr,
  output logic [31:0] mainRdata,
  output logic [15:0] xmemRdata,
  output logic [15:0] ymemRdata
);
  initial
  begin
    mainRdata = 32'h00000000;
    xmemRdata = 16'h0000;
    ymemRdata = 16'h0000;
  end

  // Address-derived data in the cycle a read select stands, a moving pattern otherwise
  always @(posedge mclk)
  begin
    #1;
    mainRdata = (mainSel && !mainWrite) ?
      {mainAddrBus[15:0] ^ 16'h8A5C, mainAddrBus[15:0] ^ 16'h9234} : ~mainRdata;
    xmemRdata = (xmemSel && !xmemWrite) ? xmemAddr[15:0] ^ 16'h8A5C : ~xmemRdata;
    ymemRdata = (ymemSel && !ymemWrite) ? ymemAddr[15:0] ^ 16'h1234 : ~ymemRdata;
  end
endmodule

// File: verif/dsp_data_transfer_decode_tb_top.sv
`timescale 1ns/1ns
module dsp_data_transfer_decode_tb_top
  import dsp_xfer_pkg::*;
;
  typedef struct packed {
    logic [15:0] w;
    logic [1:0] sel;
    logic [1:0] wr;
    logic [31:0] xa;
    logic [31:0] ya;
    ptr_wb_t px;
    ptr_wb_t py;
  } row_t;
  logic mclk, rst, instValid, mainGrant, condFlagIn;
  logic [15:0] instWord, xmemRdata, ymemRdata, xmemWdata, ymemWdata;
  logic [31:0] gr2, gr3, gr4, gr5, gr6, gr7, xIndex, yIndex, mainRdata;
  logic instStall, mainSel, mainWrite, mainLong, xmemSel, xmemWrite, ymemSel, ymemWrite;
  logic condFlag;
  logic [31:0] mainAddrBus, mainWdata, xmemAddr, ymemAddr;
  ptr_wb_t ptrWbX, ptrWbY;
  dsp_regs_t dspRegs;
  int n_fail, compares;
  logic [3:0] codes [10] = '{4'h5, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF};
  row_t rows [4] = '{
    '{16'hF3D9, 2'b11, 2'b01, 32'h5000, 32'h7000, '{1'b1, 3'h5, 32'h5002}, '0},
    '{16'hF02F, 2'b11, 2'b10, 32'h4000, 32'h6000, '{1'b1, 3'h4, 32'h4010}, '{1'b1, 3'h6, 32'h6020}},
    '{16'hF342, 2'b01, 2'b00, 32'h0, 32'h7000, '0, '{1'b1, 3'h7, 32'h7002}},
    '{16'hF000, 2'b00, 2'b00, 32'h0, 32'h0, '0, '0}};

  dsp_data_transfer_decode uut (.mclk(mclk), .rst(rst), .instValid(instValid),
    .instWord(instWord), .gr2(gr2), .gr3(gr3), .gr4(gr4), .gr5(gr5), .gr6(gr6), .gr7(gr7),
    .xIndex(xIndex), .yIndex(yIndex), .mainRdata(mainRdata), .mainGrant(mainGrant),
    .xmemRdata(xmemRdata), .ymemRdata(ymemRdata), .condFlagIn(condFlagIn),
    .instStall(instStall), .mainSel(mainSel), .mainWrite(mainWrite), .mainLong(mainLong),
    .mainAddrBus(mainAddrBus), .mainWdata(mainWdata), .xmemSel(xmemSel),
    .xmemWrite(xmemWrite), .xmemAddr(xmemAddr), .xmemWdata(xmemWdata), .ymemSel(ymemSel),
    .ymemWrite(ymemWrite), .ymemAddr(ymemAddr), .ymemWdata(ymemWdata), .ptrWbX(ptrWbX),
    .ptrWbY(ptrWbY), .dspRegs(dspRegs), .condFlag(condFlag));

  dsp_mem_model mem (.mclk(mclk), .mainSel(mainSel), .mainWrite(mainWrite),
    .mainAddrBus(mainAddrBus), .xmemSel(xmemSel), .xmemWrite(xmemWrite), .xmemAddr(xmemAddr),
    .ymemSel(ymemSel), .ymemWrite(ymemWrite), .ymemAddr(ymemAddr), .mainRdata(mainRdata),
    .xmemRdata(xmemRdata), .ymemRdata(ymemRdata));

  // Clock
  always #5 mclk = ~mclk;

  // Compare and count
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    compares++;
    if (got !== exp)
    begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask

  // One instruction, taken at the next edge
  task automatic issue(input logic [15:0] w, input logic g);
    @(posedge mclk);
    #1;
    instWord = w;
    instValid = 1'b1;
    mainGrant = g;
    @(posedge mclk);
    #1;
    instValid = 1'b0;
    mainGrant = 1'b0;
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Run limit
  initial
  begin
    #200000;
    n_fail++;
    end_of_test();
  end

  // Main sequence
  initial
  begin
    {mclk, instValid, mainGrant, condFlagIn, instWord} = '0;
    {gr2, gr3, gr4, gr5} = {32'h2000, 32'h3000, 32'h4000, 32'h5000};
    {gr6, gr7, xIndex, yIndex} = {32'h6000, 32'h7000, 32'h10, 32'h20};
    rst = 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    rst = 1'b0;
    chk("idle", '0, {mainSel, xmemSel, ymemSel, instStall, ptrWbX.we, dspRegs.a0});
    $display("Test reset done");
    // Every register code: long load, then long store
    foreach (codes[k])
    begin
      issue({8'hF4, codes[k], 4'h6}, 1'b1);
      chk("loadReq", {4'b1010, 32'h4000}, {mainSel, mainWrite, mainLong, ptrWbX.we, mainAddrBus});
      issue({8'hF5, codes[k], 4'h7}, 1'b1);
      chk("storeReq", {4'b1110, 32'h5000}, {mainSel, mainWrite, mainLong, ptrWbX.we, mainAddrBus});
      if (codes[k] == 4'hD || codes[k] == 4'hF)
        chk("guardData", 8'h34, mainWdata[7:0]);
      else
        chk("storeData", 32'hCA5CD234, mainWdata);
    end
    $display("Test register codes done");
    // Parallel rows issued back to back
    for (int i = 0; i <= 4; i++)
    begin
      @(posedge mclk);
      #1;
      if (i > 0)
      begin
        chk("xySel", rows[i-1].sel, {xmemSel, ymemSel});
        chk("xyWrite", rows[i-1].wr, {xmemWrite, ymemWrite});
        if (rows[i-1].sel[1]) chk("xAddr", rows[i-1].xa, xmemAddr);
        if (rows[i-1].sel[0]) chk("yAddr", rows[i-1].ya, ymemAddr);
        chk("ptrX", rows[i-1].px, rows[i-1].px.we ? ptrWbX : {ptrWbX.we, 35'h0});
        chk("ptrY", rows[i-1].py, rows[i-1].py.we ? ptrWbY : {ptrWbY.we, 35'h0});
        if (rows[i-1].wr[1]) chk("xWdata", 16'hCA5C, xmemWdata);
        if (rows[i-1].wr[0]) chk("yWdata", 16'hCA5C, ymemWdata);
      end
      instValid = (i < 4);
      instWord = rows[i % 4].w;
    end
    @(posedge mclk);
    #1;
    chk("xyLoads", {32'hDA5C0000, 32'h72340000}, {dspRegs.x1, dspRegs.y0});
    chk("yLoad", 32'h62340000, dspRegs.y1);
    $display("Test parallel rows done");
    // Word load with predecrement and guard sign fill
    issue(16'hF550, 1'b1);
    chk("predecAddr", 32'h4FFE, mainAddrBus);
    chk("predecPtr", {1'b1, 3'h5, 32'h4FFE}, ptrWbX);
    @(posedge mclk);
    #1;
    chk("wordLoad", 32'hDDCA0000, dspRegs.a1);
    chk("guardFill", 8'hFF, dspRegs.a1g);
    issue(16'hF75D, 1'b1);
    chk("wordStore", {2'b10, 16'hDDCA}, {mainWrite, mainLong, mainWdata[15:0]});
    chk("indexPtr", {1'b1, 3'h3, 32'h3010}, ptrWbX);
    issue(16'hF673, 1'b1);
    chk("longPredec", {1'b1, 32'h1FFC}, {mainLong, mainAddrBus});
    chk("longPtr", {1'b1, 3'h2, 32'h1FFC}, ptrWbX);
    chk("longData", 32'hCA5CD234, mainWdata);
    $display("Test single modes done");
    // Refused without grant, then reissued
    condFlagIn = 1'b1;
    issue(16'hF476, 1'b0);
    chk("stall", 3'b101, {instStall, mainSel, condFlag});
    issue(16'hF476, 1'b1);
    chk("reissue", 2'b01, {instStall, mainSel});
    $display("Test arbitration done");
    end_of_test();
  end
endmodule

bind dsp_data_transfer_decode dsp_xfer_monitor mon (.mclk(mclk), .rst(rst),
  .instValid(instValid), .instWord(instWord), .gr4(gr4), .gr5(gr5), .mainGrant(mainGrant),
  .xmemRdata(xmemRdata), .condFlagIn(condFlagIn), .instStall(instStall), .mainSel(mainSel),
  .xmemSel(xmemSel), .xmemWrite(xmemWrite), .ymemSel(ymemSel), .ymemWrite(ymemWrite),
  .ptrWbX(ptrWbX), .ptrWbY(ptrWbY), .dspRegs(dspRegs), .condFlag(condFlag));
